// >>> shared/ddrc_defs.vh
// Register map, field positions, reset values and timing counts for the DDR retimer control
`ifndef DDRC_DEFS_VH
`define DDRC_DEFS_VH

// ----------------------------------------------------------------------
// Register indices and byte addresses (index times four)
// ----------------------------------------------------------------------
`define DDRC_IDX_DATA_CTRL  8'h02
`define DDRC_IDX_MEM_ADDR   8'h10
`define DDRC_IDX_MEM_DATA   8'h11
`define DDRC_IDX_CAL_CMD    8'h12
`define DDRC_IDX_PHASE_CTRL 8'h14
`define DDRC_IDX_CAL_STAT   8'h15
`define DDRC_IDX_HW_REV     8'h1f
`define DDRC_ADDR_DATA_CTRL  10'h008
`define DDRC_ADDR_MEM_ADDR   10'h040
`define DDRC_ADDR_MEM_DATA   10'h044
`define DDRC_ADDR_CAL_CMD    10'h048
`define DDRC_ADDR_PHASE_CTRL 10'h050
`define DDRC_ADDR_CAL_STAT   10'h054
`define DDRC_ADDR_HW_REV     10'h07c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DDRC_DC_TWOS       3
`define DDRC_DC_EDGE       4
`define DDRC_DC_ORDER      5
`define DDRC_CC_Q_CLR      7
`define DDRC_CC_I_CLR      6
`define DDRC_CC_CAL_START  4
`define DDRC_CC_MEM_WR     3
`define DDRC_CC_MEM_RD     2
`define DDRC_CC_Q_RESTORE  1
`define DDRC_CC_I_RESTORE  0
`define DDRC_PC_Q_HI       7
`define DDRC_PC_Q_LO       6
`define DDRC_PC_SEARCH     4
`define DDRC_PC_REACQ      3
`define DDRC_PC_OVERRIDE   2
`define DDRC_PC_I_HI       1
`define DDRC_PC_I_LO       0

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define DDRC_RST_DATA_CTRL 8'h00
`define DDRC_RST_PHASE     2'h0
`define DDRC_COEF_DEFAULT  6'h20
`define DDRC_SEARCH_CYCLES 8'h80
`define DDRC_CAL_CYCLES    8'h40

`endif

// >>> rtl/ddrc_top.v
// DDR sample capture, retimer phase selection and calibration register control
//
// Functional notes
// - Samples arrive on one shared bus qualified by the host data clock
// - I and Q words alternate, one of each per data clock period
// - Sample bus is 8, 10, 12 or 14 bits wide by variant
// - Up to 250 MSPS combined with a 125 MHz data clock
// - Pair order and capture edge bits give four capture arrangements
// - Format bit selects unsigned binary or twos complement input
// - Writing one to bits 7/6 of 0x12 clears Q/I calibration complete
// - Writing one to bit 4 of 0x12 starts self-calibration
// - Writing one to bit 3 stores staged data at staged coefficient address
// - Writing one to bit 2 reads one coefficient from memory
// - Writing one to bit 1 restores Q coefficients to defaults
// - Writing one to bit 0 restores I coefficients to defaults
// - Without override the phase fields are read-only retimer results
// - With override the I field is writable and forces both paths
// - With override the Q field at bits 7:6 is writable
// - Bit 4 of 0x14 reads one while the retimer is searching
// - A written 0-to-1 on bit 3 of 0x14 restarts phase detection once searching has cleared
// - Read-only 8-bit revision register at 0x1F
// - Bit 4 of 0x02 selects rising or falling capture edge
// - Bit 5 of 0x02 selects whether I or Q comes first
// - Phase codes map 00 to phase 2, 01/10 to 3, 11 to 1
// - After reset a phase is chosen within 128 cycles, then searching clears
`include "ddrc_defs.vh"
`default_nettype none

module ddrc_top #(
  parameter       DW      = 14,
  parameter [7:0] HW_REV  = 8'h5c, // Arbitrary value
  parameter       COEF_N  = 64
) (
  // APB clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // APB slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [9:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  // Host sample link
  input  wire          host_data_clock,
  input  wire [DW-1:0] sample_bus,
  // Converter side
  input  wire          converter_clock,
  output reg  [DW-1:0] i_sample_ff,
  output reg  [DW-1:0] q_sample_ff,
  output reg           sample_valid_ff,
  output reg  [1:0]    retimer_phase_ff
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  reg [2:0]    dclk_sync_ff;
  reg [2:0]    cclk_sync_ff;
  reg [DW-1:0] bus_s1_ff;
  reg [DW-1:0] bus_s2_ff;
  reg [DW-1:0] bus_s3_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dclk_sync_ff <= 3'h0;
      cclk_sync_ff <= 3'h0;
      bus_s1_ff    <= {DW{1'b0}};
      bus_s2_ff    <= {DW{1'b0}};
      bus_s3_ff    <= {DW{1'b0}};
    end else begin
      dclk_sync_ff <= {dclk_sync_ff[1:0], host_data_clock};
      cclk_sync_ff <= {cclk_sync_ff[1:0], converter_clock};
      bus_s1_ff    <= sample_bus;
      bus_s2_ff    <= bus_s1_ff;
      bus_s3_ff    <= bus_s2_ff;
    end
  end

  wire dclk_rise = dclk_sync_ff[1] & ~dclk_sync_ff[2];
  wire dclk_fall = ~dclk_sync_ff[1] & dclk_sync_ff[2];
  wire cclk_rise = cclk_sync_ff[1] & ~cclk_sync_ff[2];

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  reg          twos_ff;
  reg          edge_sel_ff;
  reg          pair_order_sel_ff;
  reg [5:0]    mem_addr_ff;
  reg [5:0]    mem_data_ff;
  reg          phase_override_ff;
  reg [1:0]    i_force_ff;
  reg [1:0]    q_force_ff;
  reg          reacq_lvl_ff;
  reg          i_cal_complete_ff;
  reg          q_cal_complete_ff;
  reg          cal_busy_ff;
  reg [7:0]    cal_cnt_ff;
  reg [5:0]    i_coef_ff [0:COEF_N-1];
  reg [5:0]    q_coef_ff [0:COEF_N-1];

  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & ~penable & ~pwrite;
  wire cmd_wr = wr_en & (paddr == `DDRC_ADDR_CAL_CMD);
  wire q_cal_status_clear = cmd_wr & pwdata[`DDRC_CC_Q_CLR];
  wire i_cal_status_clear = cmd_wr & pwdata[`DDRC_CC_I_CLR];
  wire self_cal_start     = cmd_wr & pwdata[`DDRC_CC_CAL_START];
  wire coef_mem_write     = cmd_wr & pwdata[`DDRC_CC_MEM_WR];
  wire coef_mem_read      = cmd_wr & pwdata[`DDRC_CC_MEM_RD];
  wire q_coef_restore     = cmd_wr & pwdata[`DDRC_CC_Q_RESTORE];
  wire i_coef_restore     = cmd_wr & pwdata[`DDRC_CC_I_RESTORE];
  wire pc_wr = wr_en & (paddr == `DDRC_ADDR_PHASE_CTRL);
  wire reacquire = pc_wr & pwdata[`DDRC_PC_REACQ] & ~reacq_lvl_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      twos_ff           <= 1'b0;
      edge_sel_ff       <= 1'b0;
      pair_order_sel_ff <= 1'b0;
      mem_addr_ff       <= 6'h00;
      mem_data_ff       <= 6'h00;
      phase_override_ff <= 1'b0;
      i_force_ff        <= `DDRC_RST_PHASE;
      q_force_ff        <= `DDRC_RST_PHASE;
      reacq_lvl_ff      <= 1'b0;
    end else begin
      if (wr_en && paddr == `DDRC_ADDR_DATA_CTRL) begin
        twos_ff           <= pwdata[`DDRC_DC_TWOS];
        edge_sel_ff       <= pwdata[`DDRC_DC_EDGE];
        pair_order_sel_ff <= pwdata[`DDRC_DC_ORDER];
      end
      if (wr_en && paddr == `DDRC_ADDR_MEM_ADDR)
        mem_addr_ff <= pwdata[5:0];
      if (wr_en && paddr == `DDRC_ADDR_MEM_DATA)
        mem_data_ff <= pwdata[5:0];
      else if (coef_mem_read)
        mem_data_ff <= i_coef_ff[mem_addr_ff];
      if (pc_wr) begin
        reacq_lvl_ff      <= pwdata[`DDRC_PC_REACQ];
        phase_override_ff <= pwdata[`DDRC_PC_OVERRIDE];
        if (phase_override_ff) begin
          i_force_ff <= pwdata[`DDRC_PC_I_HI:`DDRC_PC_I_LO];
          q_force_ff <= pwdata[`DDRC_PC_Q_HI:`DDRC_PC_Q_LO];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Coefficient memory
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < COEF_N; g = g + 1) begin : g_coef
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          i_coef_ff[g] <= `DDRC_COEF_DEFAULT;
          q_coef_ff[g] <= `DDRC_COEF_DEFAULT;
        end else begin
          if (i_coef_restore)
            i_coef_ff[g] <= `DDRC_COEF_DEFAULT;
          else if (coef_mem_write && mem_addr_ff == g)
            i_coef_ff[g] <= mem_data_ff;
          if (q_coef_restore)
            q_coef_ff[g] <= `DDRC_COEF_DEFAULT;
          else if (coef_mem_write && mem_addr_ff == g)
            q_coef_ff[g] <= mem_data_ff;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Self-calibration sequencer
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_busy_ff       <= 1'b0;
      cal_cnt_ff        <= 8'h00;
      i_cal_complete_ff <= 1'b0;
      q_cal_complete_ff <= 1'b0;
    end else begin
      if (self_cal_start && !cal_busy_ff) begin
        cal_busy_ff <= 1'b1;
        cal_cnt_ff  <= `DDRC_CAL_CYCLES;
      end else if (cal_busy_ff) begin
        cal_cnt_ff <= cal_cnt_ff - 8'h01;
        if (cal_cnt_ff == 8'h01)
          cal_busy_ff <= 1'b0;
      end
      // Completion wins over a clear in the same cycle
      if (cal_busy_ff && cal_cnt_ff == 8'h01) begin
        i_cal_complete_ff <= 1'b1;
        q_cal_complete_ff <= 1'b1;
      end else begin
        if (i_cal_status_clear)
          i_cal_complete_ff <= 1'b0;
        if (q_cal_status_clear)
          q_cal_complete_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Phase search
  // ----------------------------------------------------------------------
  localparam [2:0] ST_SEARCH = 3'h1;
  localparam [2:0] ST_LOCK   = 3'h2;
  localparam [2:0] ST_IDLE   = 3'h4;

  reg [2:0] st_ff;
  reg [7:0] srch_cnt_ff;
  reg [5:0] since_dclk_ff;
  reg [5:0] dclk_per_ff;
  reg [1:0] i_auto_ff;
  reg [1:0] q_auto_ff;

  // Quadrant of converter edge within the data clock period
  wire [1:0] quad = (dclk_per_ff == 6'h00) ? 2'h0 :
                    (since_dclk_ff < {2'h0, dclk_per_ff[5:2]}) ? 2'h0 :
                    (since_dclk_ff < {1'b0, dclk_per_ff[5:1]}) ? 2'h1 :
                    (since_dclk_ff < dclk_per_ff - {2'h0, dclk_per_ff[5:2]}) ? 2'h2 :
                    2'h3;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff         <= ST_SEARCH;
      srch_cnt_ff   <= 8'h00;
      since_dclk_ff <= 6'h00;
      dclk_per_ff   <= 6'h00;
      i_auto_ff     <= `DDRC_RST_PHASE;
      q_auto_ff     <= `DDRC_RST_PHASE;
    end else begin
      if (dclk_rise) begin
        since_dclk_ff <= 6'h00;
        dclk_per_ff   <= since_dclk_ff + 6'h01;
      end else if (since_dclk_ff != 6'h3f) begin
        since_dclk_ff <= since_dclk_ff + 6'h01;
      end
      case (st_ff)
        ST_SEARCH: begin
          srch_cnt_ff <= srch_cnt_ff + 8'h01;
          if (cclk_rise) begin
            i_auto_ff <= quad;
            q_auto_ff <= quad;
          end
          if (srch_cnt_ff == `DDRC_SEARCH_CYCLES - 8'h02)
            st_ff <= ST_LOCK;
        end
        ST_LOCK: begin
          st_ff <= ST_IDLE;
        end
        ST_IDLE: begin
          if (reacquire) begin
            st_ff       <= ST_SEARCH;
            srch_cnt_ff <= 8'h00;
          end
        end
        default: begin
          st_ff <= ST_SEARCH;
        end
      endcase
    end
  end

  wire       searching = st_ff[0] | st_ff[1];
  wire [1:0] i_mode = phase_override_ff ? i_force_ff : i_auto_ff;
  wire [1:0] q_mode = phase_override_ff ? q_force_ff : q_auto_ff;

  // ----------------------------------------------------------------------
  // DDR capture and retiming
  // ----------------------------------------------------------------------
  reg [DW-1:0] first_ff;
  reg [DW-1:0] pair_i_ff;
  reg [DW-1:0] pair_q_ff;
  reg          pair_tgl_ff;
  reg          pair_seen_ff;
  reg [1:0]    rt_dly_ff;

  wire         cap_first  = edge_sel_ff ? dclk_rise : dclk_fall;
  wire         cap_second = edge_sel_ff ? dclk_fall : dclk_rise;
  wire [DW-1:0] fmt = twos_ff ? bus_s3_ff : {~bus_s3_ff[DW-1], bus_s3_ff[DW-2:0]};

  // Retimer phase delay in pclk cycles: phase 1, 2, 3
  reg [1:0] rt_phase;
  always @* begin
    case (i_mode)
      2'h0:    rt_phase = 2'h2;
      2'h3:    rt_phase = 2'h1;
      default: rt_phase = 2'h3;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_ff         <= {DW{1'b0}};
      pair_i_ff        <= {DW{1'b0}};
      pair_q_ff        <= {DW{1'b0}};
      pair_tgl_ff      <= 1'b0;
      pair_seen_ff     <= 1'b0;
      rt_dly_ff        <= 2'h0;
      i_sample_ff      <= {DW{1'b0}};
      q_sample_ff      <= {DW{1'b0}};
      sample_valid_ff  <= 1'b0;
      retimer_phase_ff <= 2'h0;
    end else begin
      retimer_phase_ff <= rt_phase;
      sample_valid_ff  <= 1'b0;
      if (cap_first)
        first_ff <= fmt;
      if (cap_second) begin
        pair_i_ff   <= pair_order_sel_ff ? first_ff : fmt;
        pair_q_ff   <= pair_order_sel_ff ? fmt : first_ff;
        pair_tgl_ff <= 1'b1;
        rt_dly_ff   <= 2'h0;
      end else if (pair_tgl_ff) begin
        rt_dly_ff <= rt_dly_ff + 2'h1;
        if (rt_dly_ff + 2'h1 == rt_phase) begin
          pair_tgl_ff <= 1'b0;
          pair_seen_ff <= 1'b1;
        end
      end
      // Retimed pair handed to converter outputs once per data clock period
      if (pair_seen_ff) begin
        pair_seen_ff    <= 1'b0;
        i_sample_ff     <= pair_i_ff;
        q_sample_ff     <= pair_q_ff;
        sample_valid_ff <= ~searching;
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  reg [7:0] rd_mux;
  reg       rd_err;
  always @* begin
    rd_err = 1'b0;
    case (paddr)
      `DDRC_ADDR_DATA_CTRL:  rd_mux = {2'h0, pair_order_sel_ff, edge_sel_ff, twos_ff, 3'h0};
      `DDRC_ADDR_MEM_ADDR:   rd_mux = {2'h0, mem_addr_ff};
      `DDRC_ADDR_MEM_DATA:   rd_mux = {2'h0, mem_data_ff};
      `DDRC_ADDR_CAL_CMD:    rd_mux = 8'h00;
      `DDRC_ADDR_PHASE_CTRL: rd_mux = {q_mode, 1'b0, searching, reacq_lvl_ff,
                                       phase_override_ff, i_mode};
      `DDRC_ADDR_CAL_STAT:   rd_mux = {q_cal_complete_ff, i_cal_complete_ff, 5'h00,
                                       cal_busy_ff};
      `DDRC_ADDR_HW_REV:     rd_mux = HW_REV;
      default: begin
        rd_mux = 8'h00;
        rd_err = 1'b1;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & rd_err;
      if (rd_en)
        prdata <= {24'h000000, rd_mux};
    end
  end

endmodule

`default_nettype wire

// >>> tb/ddrc_chk_assertions.sv
// Checker for the register port and sample outputs of the DDR retimer control
`include "ddrc_defs.vh"
`default_nettype none
module ddrc_chk #(
  parameter [7:0] HW_REV = 8'h5c // Arbitrary value
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register port
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Converter side
  input wire logic        sample_valid_ff,
  input wire logic [1:0]  retimer_phase_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic       setup;
  logic       mapped;
  logic [7:0] since_rst_ff;
  assign setup  = psel && !penable;
  assign mapped = paddr inside {`DDRC_ADDR_DATA_CTRL, `DDRC_ADDR_MEM_ADDR, `DDRC_ADDR_MEM_DATA,
    `DDRC_ADDR_CAL_CMD, `DDRC_ADDR_PHASE_CTRL, `DDRC_ADDR_CAL_STAT, `DDRC_ADDR_HW_REV};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      since_rst_ff <= 8'h00;
    else if (since_rst_ff != 8'hff)
      since_rst_ff <= since_rst_ff + 8'h01;
  end
  a_ready_setup: assert property (setup |=> pready && psel && penable)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (setup && !mapped |=> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_err_mapped: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_rev_read: assert property (
    setup && !pwrite && paddr == `DDRC_ADDR_HW_REV |=> prdata == {24'h0, HW_REV})
    else $error("revision read wrong");
  a_search_early: assert property (
    setup && !pwrite && paddr == `DDRC_ADDR_PHASE_CTRL && since_rst_ff < 8'h64
    |=> prdata[`DDRC_PC_SEARCH]) else $error("searching low too early");
  a_valid_early: assert property (sample_valid_ff |-> since_rst_ff >= 8'h64)
    else $error("valid sample while searching");
  a_valid_pulse: assert property (sample_valid_ff |=> !sample_valid_ff)
    else $error("valid longer than one cycle");
  a_valid_phase: assert property (sample_valid_ff |-> retimer_phase_ff != 2'h0)
    else $error("valid sample without phase");
endmodule
bind ddrc_top ddrc_chk #(.HW_REV(HW_REV)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sample_valid_ff(sample_valid_ff), .retimer_phase_ff(retimer_phase_ff));
`default_nettype wire

// >>> tb/ddrc_host_model.sv
// Host model that streams interleaved I and Q words on the DDR sample bus
`default_nettype none
module ddrc_host #(
  parameter DW = 14
) (
  // Bench control
  input  wire logic          go,
  input  wire logic          order_sel,
  input  wire logic          edge_sel,
  input  wire logic [DW-1:0] base,
  // Sample link
  output wire logic          host_data_clock,
  output var  logic [DW-1:0] sample_bus
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DW-1:0] iw;
  logic [DW-1:0] qw;
  logic          act;
  // Clock idles at the level before the first capture edge
  assign host_data_clock = act ? edge_sel : !edge_sel;
  initial begin
    sample_bus = '0;
    act = 1'b0;
    forever begin
      @(posedge go);
      for (int k = 0; k < 3; k++) begin
        iw = base + DW'(2 * k);
        qw = base + DW'(2 * k + 1);
        sample_bus = order_sel ? iw : qw;
        #16 act = 1'b1;
        #16 sample_bus = order_sel ? qw : iw;
        #16 act = 1'b0;
        #16;
      end
      sample_bus = ~sample_bus;
    end
  end
endmodule
`default_nettype wire

// >>> tb/dual_dac_ddr_input_retimer_ctrl_tb.sv
// Testbench for the DDR retimer control block
`include "ddrc_defs.vh"
`default_nettype none
module dual_dac_ddr_input_retimer_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [7:0] REV = 8'h3a; // Arbitrary value
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, go, order_sel, edge_sel;
  logic        host_data_clock, converter_clock, sample_valid_ff, er;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] sample_bus, i_sample_ff, q_sample_ff, base;
  logic [1:0]  retimer_phase_ff;
  int          fail_count, samples_checked;
  ddrc_top #(.DW(14), .HW_REV(REV)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_data_clock(host_data_clock),
    .sample_bus(sample_bus), .converter_clock(converter_clock), .i_sample_ff(i_sample_ff),
    .q_sample_ff(q_sample_ff), .sample_valid_ff(sample_valid_ff),
    .retimer_phase_ff(retimer_phase_ff));
  ddrc_host #(.DW(14)) host (.go(go), .order_sel(order_sel), .edge_sel(edge_sel),
    .base(base), .host_data_clock(host_data_clock), .sample_bus(sample_bus));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("BAD pready expected 1 seen %b", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input string nm, input logic [9:0] a, input logic [7:0] m, e);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rd & {24'h0, m});
  endtask
  task automatic wait_lock;
    int n;
    n = 0;
    do begin
      apb(1'b0, `DDRC_ADDR_PHASE_CTRL, 8'h00);
      n++;
    end while (rd[4] !== 1'b0 && n < 50);
    chk("searching", 32'h0, {31'h0, rd[4]});
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rchk("searching after reset", `DDRC_ADDR_PHASE_CTRL, 8'h10, 8'h10);
    rchk("data ctrl reset", `DDRC_ADDR_DATA_CTRL, 8'hff, 8'h00);
    wait_lock();
    chk("auto phase", 32'h1, {31'h0, retimer_phase_ff != 2'h0});
    apb(1'b1, `DDRC_ADDR_HW_REV, 8'hff);
    rchk("revision", `DDRC_ADDR_HW_REV, 8'hff, REV);
    apb(1'b0, 10'h00c, 8'h00);
    chk("unmapped", 32'h1, {rd[30:0], er});
  endtask
  task automatic t_phase;
    logic [7:0] p0;
    logic [1:0] pmap [4];
    pmap = '{2'h2, 2'h3, 2'h3, 2'h1};
    apb(1'b0, `DDRC_ADDR_PHASE_CTRL, 8'h00);
    p0 = rd[7:0];
    apb(1'b1, `DDRC_ADDR_PHASE_CTRL, ~p0 & 8'hc3);
    rchk("fields read only", `DDRC_ADDR_PHASE_CTRL, 8'hc7, p0 & 8'hc3);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `DDRC_ADDR_PHASE_CTRL, 8'h04);
      apb(1'b1, `DDRC_ADDR_PHASE_CTRL, {c[1:0], 4'h1, c[1:0]});
      rchk("forced fields", `DDRC_ADDR_PHASE_CTRL, 8'hc7, {c[1:0], 4'h1, c[1:0]});
      repeat (3) @(posedge pclk);
      chk("forced phase", {30'h0, pmap[c]}, {30'h0, retimer_phase_ff});
    end
    apb(1'b1, `DDRC_ADDR_PHASE_CTRL, 8'h00);
    apb(1'b1, `DDRC_ADDR_PHASE_CTRL, 8'h08);
    rchk("reacquire", `DDRC_ADDR_PHASE_CTRL, 8'h10, 8'h10);
    wait_lock();
    apb(1'b1, `DDRC_ADDR_PHASE_CTRL, 8'h08);
    rchk("steady level", `DDRC_ADDR_PHASE_CTRL, 8'h10, 8'h00);
    apb(1'b1, `DDRC_ADDR_PHASE_CTRL, 8'h00);
  endtask
  task automatic t_cal;
    apb(1'b1, `DDRC_ADDR_CAL_CMD, 8'h10);
    rchk("cal busy", `DDRC_ADDR_CAL_STAT, 8'hc1, 8'h01);
    repeat (70) @(posedge pclk);
    rchk("cal done", `DDRC_ADDR_CAL_STAT, 8'hc1, 8'hc0);
    apb(1'b1, `DDRC_ADDR_CAL_CMD, 8'h80);
    rchk("q clear", `DDRC_ADDR_CAL_STAT, 8'hc1, 8'h40);
    apb(1'b1, `DDRC_ADDR_CAL_CMD, 8'h40);
    rchk("i clear", `DDRC_ADDR_CAL_STAT, 8'hc1, 8'h00);
  endtask
  task automatic t_mem;
    apb(1'b1, `DDRC_ADDR_MEM_ADDR, 8'h05);
    apb(1'b1, `DDRC_ADDR_MEM_DATA, 8'h15);
    apb(1'b1, `DDRC_ADDR_CAL_CMD, 8'h08);
    apb(1'b1, `DDRC_ADDR_MEM_DATA, 8'h00);
    apb(1'b1, `DDRC_ADDR_CAL_CMD, 8'h04);
    rchk("coef stored", `DDRC_ADDR_MEM_DATA, 8'h3f, 8'h15);
    apb(1'b1, `DDRC_ADDR_CAL_CMD, 8'h02);
    apb(1'b1, `DDRC_ADDR_CAL_CMD, 8'h04);
    rchk("q restore only", `DDRC_ADDR_MEM_DATA, 8'h3f, 8'h15);
    apb(1'b1, `DDRC_ADDR_CAL_CMD, 8'h01);
    apb(1'b1, `DDRC_ADDR_CAL_CMD, 8'h04);
    rchk("i restore", `DDRC_ADDR_MEM_DATA, 8'h3f, 8'h20);
  endtask
  task automatic t_stream(input logic [2:0] cfg);
    logic [13:0] msb;
    int          n;
    msb = cfg[0] ? 14'h0000 : 14'h2000;
    order_sel <= cfg[2];
    edge_sel <= cfg[1];
    base <= 14'h1ffd + 14'(cfg);
    apb(1'b1, `DDRC_ADDR_DATA_CTRL, {2'h0, cfg, 3'h0});
    repeat (20) @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (sample_valid_ff !== 1'b1 && n < 60);
      chk("sample valid", 32'h1, {31'h0, sample_valid_ff});
      chk("i word", {18'h0, (base + 14'(2 * k)) ^ msb}, {18'h0, i_sample_ff});
      chk("q word", {18'h0, (base + 14'(2 * k + 1)) ^ msb}, {18'h0, q_sample_ff});
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Clocks, main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    converter_clock = 1'b0;
    #11;
    forever #32 converter_clock = ~converter_clock;
  end
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
  initial begin
    {presetn, psel, penable, pwrite, go, order_sel} = 6'h00;
    edge_sel = 1'b1;
    paddr = 10'h000;
    pwdata = 32'h0;
    base = 14'h0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_phase();
    t_cal();
    t_mem();
    t_stream(3'b010);
    t_stream(3'b111);
    t_stream(3'b001);
    t_stream(3'b100);
    complete_run();
  end
endmodule
`default_nettype wire
